// File: logic/cwpc_pkg.sv
// shared constants and carriers for the code and write protection block
package cwpc_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADDR_CFG1 = 8'h00; // first configuration word image
    localparam logic [7:0] ADDR_CFG2 = 8'h04; // config_word_two
    localparam logic [7:0] ADDR_STATUS = 8'h08; // status and sticky violation flags
    localparam logic [7:0] ADDR_CTRL = 8'h0C; // load strobe and variant
    // configuration word widths and reset values
    localparam int CFG_W = 14;
    localparam logic [13:0] CFG_RESET = 14'h3FFF; // erased state reads ones
    // first word field positions
    localparam int CFG1_PROG_GUARD_BIT = 7; // program_read_guard_n
    localparam int CFG1_EE_GUARD_BIT = 8; // eeprom_read_guard_n
    // second word field positions
    localparam int CFG2_LVP_BIT = 13; // low_voltage_prog_enable
    localparam int CFG2_PLL_BIT = 8; // clock_multiplier_enable
    localparam int CFG2_VCAP_LO = 4; // regulator_cap_pin_select low bit
    localparam int CFG2_WRT_LO = 0; // self_write_guard_size low bit
    // unimplemented positions forced to one: bit 11, 7-6, 3-2
    localparam logic [13:0] CFG2_UNIMPL_MASK = 14'h08CC;
    localparam logic [1:0] VCAP_NONE = 2'h3; // low-voltage variant reading
    // self-write guard encodings
    localparam logic [1:0] WRT_OFF = 2'h3;
    localparam logic [1:0] WRT_SMALL = 2'h2;
    localparam logic [1:0] WRT_HALF = 2'h1;
    localparam logic [1:0] WRT_ALL = 2'h0;
    // last protected address for each guarded size, 4k-word memory
    localparam logic [11:0] WRT_SMALL_TOP = 12'h1FF;
    localparam logic [11:0] WRT_HALF_TOP = 12'h7FF;
    localparam logic [11:0] WRT_ALL_TOP = 12'hFFF;
    localparam int PADDR_W = 12; // program memory address width
    localparam int EADDR_W = 8; // data eeprom address width
    // control register bits
    localparam int CTRL_LOAD_BIT = 0; // write 1 to latch staged words
    localparam int CTRL_LV_VARIANT_BIT = 1; // low-voltage family variant
    // status register bits
    localparam int ST_PROG_LOCK_BIT = 0;
    localparam int ST_EE_LOCK_BIT = 1;
    localparam int ST_LVP_REJ_BIT = 2;
    localparam int ST_EXT_REJ_BIT = 3;
    localparam int ST_SELF_REJ_BIT = 4;
    // memory access request carrier
    typedef struct packed {
        logic req; // access request
        logic wr; // 1 write, 0 read
        logic [PADDR_W-1:0] addr; // word address
        logic [CFG_W-1:0] wdata; // write data
    } cwpc_mem_req_t;
    // gated access toward the memory array
    typedef struct packed {
        logic req; // access passed on
        logic wr; // write
        logic [PADDR_W-1:0] addr; // address
        logic [CFG_W-1:0] wdata; // write data
    } cwpc_mem_fwd_t;
endpackage

// File: logic/cwpc_top.sv
`timescale 1ns/1ns
`default_nettype none
module cwpc_top (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // programming mode entered through low-voltage method
    input wire logic lv_entry_mode,
    // external programmer program memory port
    input wire cwpc_pkg::cwpc_mem_req_t ext_prog_req,
    output logic [13:0] ext_prog_rdata,
    output logic ext_prog_refused,
    // external programmer eeprom port
    input wire cwpc_pkg::cwpc_mem_req_t ext_ee_req,
    output logic [13:0] ext_ee_rdata,
    output logic ext_ee_refused,
    // processor read and self-write request on program memory
    input wire cwpc_pkg::cwpc_mem_req_t cpu_prog_req,
    output logic cpu_self_write_refused,
    // gated requests to the arrays
    output cwpc_pkg::cwpc_mem_fwd_t prog_fwd,
    output cwpc_pkg::cwpc_mem_fwd_t ee_fwd,
    // read data returned by the arrays
    input wire logic [13:0] prog_array_rdata,
    input wire logic [13:0] ee_array_rdata,
    // applied configuration
    output logic clock_multiplier_enable,
    output logic [1:0] regulator_cap_pin_select,
    output logic low_voltage_prog_enable
);
    // returns 1 when a self-write address falls in the guarded region
    function automatic logic in_guard(input logic [1:0] size, input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        case (size)
            cwpc_pkg::WRT_SMALL: hit = (a <= cwpc_pkg::WRT_SMALL_TOP);
            cwpc_pkg::WRT_HALF: hit = (a <= cwpc_pkg::WRT_HALF_TOP);
            cwpc_pkg::WRT_ALL: hit = (a <= cwpc_pkg::WRT_ALL_TOP);
            default: hit = 1'b0; // off: nothing guarded
        endcase
        return hit;
    endfunction

    // staged words written over apb and applied words
    logic [13:0] cfg1_stage_r; // staged first word
    logic [13:0] cfg2_stage_r; // staged second word
    logic [13:0] cfg1_r; // applied first word
    logic [13:0] cfg2_r; // applied second word
    logic lv_variant_r; // low-voltage family variant
    logic lvp_rej_r; // sticky: clear of lvp refused
    logic ext_rej_r; // sticky: external access refused
    logic self_rej_r; // sticky: self-write refused
    logic [13:0] cfg2_nxt; // second word as it would be applied
    logic [13:0] cfg2_view; // applied second word as read back and driven out

    // apb decode, zero wait states
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign addr_ok = (paddr == cwpc_pkg::ADDR_CFG1) | (paddr == cwpc_pkg::ADDR_CFG2) |
                     (paddr == cwpc_pkg::ADDR_STATUS) | (paddr == cwpc_pkg::ADDR_CTRL);
    // every transfer completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok; // unmapped address answers an error

    // per-register write strobes, one cycle wide in the access phase
    logic wr_cfg1; // first word staging
    logic wr_cfg2; // second word staging
    logic wr_status; // sticky status clear
    logic wr_ctrl; // load strobe and variant
    assign wr_cfg1 = wr_en & (paddr == cwpc_pkg::ADDR_CFG1);
    assign wr_cfg2 = wr_en & (paddr == cwpc_pkg::ADDR_CFG2);
    assign wr_status = wr_en & (paddr == cwpc_pkg::ADDR_STATUS);
    assign wr_ctrl = wr_en & (paddr == cwpc_pkg::ADDR_CTRL);

    // guard bits pulled from applied words, each memory separate
    logic prog_guard_n;
    logic ee_guard_n;
    logic [1:0] self_write_guard_size;
    assign prog_guard_n = cfg1_r[cwpc_pkg::CFG1_PROG_GUARD_BIT];
    assign ee_guard_n = cfg1_r[cwpc_pkg::CFG1_EE_GUARD_BIT];
    assign self_write_guard_size = cfg2_r[cwpc_pkg::CFG2_WRT_LO +: 2];

    // first word staging, written whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg1_stage_r <= cwpc_pkg::CFG_RESET;
        end else if (wr_cfg1) begin
            cfg1_stage_r <= pwdata[cwpc_pkg::CFG_W-1:0];
        end
    end

    // second word staging; nothing reaches the pins until a load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg2_stage_r <= cwpc_pkg::CFG_RESET;
        end else if (wr_cfg2) begin
            cfg2_stage_r <= pwdata[cwpc_pkg::CFG_W-1:0];
        end
    end

    // low-voltage variant flag, written together with the load strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_variant_r <= 1'b0; // full variant after reset
        end else if (wr_ctrl) begin
            lv_variant_r <= pwdata[cwpc_pkg::CTRL_LV_VARIANT_BIT];
        end
    end

    // second word next value with lvp guard, unimplemented ones and variant
    always_comb begin
        cfg2_nxt = cfg2_stage_r | cwpc_pkg::CFG2_UNIMPL_MASK;
        // a load during low-voltage entry may not clear the enable
        if (lv_entry_mode) begin
            cfg2_nxt[cwpc_pkg::CFG2_LVP_BIT] = cfg2_r[cwpc_pkg::CFG2_LVP_BIT] |
                                               cfg2_stage_r[cwpc_pkg::CFG2_LVP_BIT];
        end
        // variant forces the no-capacitor code into the stored word too
        if (lv_variant_r) begin
            cfg2_nxt[cwpc_pkg::CFG2_VCAP_LO +: 2] = cwpc_pkg::VCAP_NONE;
        end
    end

    // load strobe
    logic load_pulse;
    // one-shot: the load bit itself is not stored
    assign load_pulse = wr_ctrl & pwdata[cwpc_pkg::CTRL_LOAD_BIT];

    // applied words: loaded at reset to erased state, then on load strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg1_r <= cwpc_pkg::CFG_RESET;
            cfg2_r <= cwpc_pkg::CFG_RESET;
        end else if (load_pulse) begin
            cfg1_r <= cfg1_stage_r;
            cfg2_r <= cfg2_nxt;
        end
    end

    // second word as software and pins see it: unimplemented ones, variant override
    always_comb begin
        cfg2_view = cfg2_r | cwpc_pkg::CFG2_UNIMPL_MASK;
        if (lv_variant_r) begin
            // holds even when the variant flag is set after the last load
            cfg2_view[cwpc_pkg::CFG2_VCAP_LO +: 2] = cwpc_pkg::VCAP_NONE;
        end
    end

    // external program, external eeprom and processor self-write gating
    logic ext_prog_block;
    logic ext_ee_block;
    logic self_block;
    assign ext_prog_block = ext_prog_req.req & ~prog_guard_n;
    assign ext_ee_block = ext_ee_req.req & ~ee_guard_n;
    assign self_block = cpu_prog_req.req & cpu_prog_req.wr &
                        in_guard(self_write_guard_size, cpu_prog_req.addr);

    // arbitration to the program array: processor first, never gated for reads
    always_comb begin
        prog_fwd = '0;
        if (cpu_prog_req.req) begin
            // processor wins the array; its reads are never held back
            prog_fwd.req = ~self_block;
            prog_fwd.wr = cpu_prog_req.wr;
            prog_fwd.addr = cpu_prog_req.addr;
            prog_fwd.wdata = cpu_prog_req.wdata;
        end else if (ext_prog_req.req) begin
            // external programmer only while the processor is idle
            prog_fwd.req = prog_guard_n;
            prog_fwd.wr = ext_prog_req.wr;
            prog_fwd.addr = ext_prog_req.addr;
            prog_fwd.wdata = ext_prog_req.wdata;
        end
    end

    // eeprom forwarding: external only, processor has its own path
    always_comb begin
        // processor eeprom traffic has its own path and is never gated here
        ee_fwd = '0;
        ee_fwd.req = ext_ee_req.req & ee_guard_n;
        ee_fwd.wr = ext_ee_req.wr;
        ee_fwd.addr = {{(cwpc_pkg::PADDR_W-cwpc_pkg::EADDR_W){1'b0}},
                       ext_ee_req.addr[cwpc_pkg::EADDR_W-1:0]};
        ee_fwd.wdata = ext_ee_req.wdata;
    end

    // external program read data registered, zeros while program memory is guarded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prog_rdata <= '0;
        end else if (prog_guard_n) begin
            ext_prog_rdata <= prog_array_rdata;
        end else begin
            ext_prog_rdata <= '0;
        end
    end

    // external eeprom read data registered, zeros while eeprom is guarded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_ee_rdata <= '0;
        end else if (ee_guard_n) begin
            ext_ee_rdata <= ee_array_rdata;
        end else begin
            ext_ee_rdata <= '0;
        end
    end

    // refusal strobes, external refused whenever its memory is guarded, even while the processor holds the array
    assign ext_prog_refused = ext_prog_block;
    assign ext_ee_refused = ext_ee_block;
    assign cpu_self_write_refused = self_block;

    // set conditions of the sticky flags
    logic lvp_rej_set; // load in low-voltage entry tried to clear the enable
    logic ext_rej_set; // an external access was refused
    assign lvp_rej_set = load_pulse & lv_entry_mode & ~cfg2_stage_r[cwpc_pkg::CFG2_LVP_BIT];
    assign ext_rej_set = ext_prog_block | ext_ee_block;

    // lvp-clear refusal flag; set wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvp_rej_r <= 1'b0;
        end else if (lvp_rej_set) begin
            lvp_rej_r <= 1'b1;
        end else if (wr_status & pwdata[cwpc_pkg::ST_LVP_REJ_BIT]) begin
            lvp_rej_r <= 1'b0; // write one clears
        end
    end

    // external refusal flag; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_rej_r <= 1'b0;
        end else if (ext_rej_set) begin
            ext_rej_r <= 1'b1;
        end else if (wr_status & pwdata[cwpc_pkg::ST_EXT_REJ_BIT]) begin
            ext_rej_r <= 1'b0; // write one clears
        end
    end

    // self-write refusal flag; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            self_rej_r <= 1'b0;
        end else if (self_block) begin
            self_rej_r <= 1'b1;
        end else if (wr_status & pwdata[cwpc_pkg::ST_SELF_REJ_BIT]) begin
            self_rej_r <= 1'b0; // write one clears
        end
    end

    // read mux
    always_comb begin
        prdata = '0;
        if (rd_en) begin
            case (paddr)
                cwpc_pkg::ADDR_CFG1: prdata[cwpc_pkg::CFG_W-1:0] = cfg1_r;
                cwpc_pkg::ADDR_CFG2: prdata[cwpc_pkg::CFG_W-1:0] = cfg2_view;
                cwpc_pkg::ADDR_STATUS: begin
                    prdata[cwpc_pkg::ST_PROG_LOCK_BIT] = ~prog_guard_n;
                    prdata[cwpc_pkg::ST_EE_LOCK_BIT] = ~ee_guard_n;
                    prdata[cwpc_pkg::ST_LVP_REJ_BIT] = lvp_rej_r;
                    prdata[cwpc_pkg::ST_EXT_REJ_BIT] = ext_rej_r;
                    prdata[cwpc_pkg::ST_SELF_REJ_BIT] = self_rej_r;
                end
                cwpc_pkg::ADDR_CTRL: prdata[cwpc_pkg::CTRL_LV_VARIANT_BIT] = lv_variant_r;
                default: prdata = '0; // unmapped
            endcase
        end
    end

    // applied configuration outputs
    assign clock_multiplier_enable = cfg2_r[cwpc_pkg::CFG2_PLL_BIT];
    assign regulator_cap_pin_select = cfg2_view[cwpc_pkg::CFG2_VCAP_LO +: 2];
    assign low_voltage_prog_enable = cfg2_r[cwpc_pkg::CFG2_LVP_BIT];
endmodule // cwpc_top
`default_nettype wire

// File: tb/cwpc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// watches the gating, register and configuration ports of the block
module cwpc_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic lv_entry_mode,
    input wire cwpc_pkg::cwpc_mem_req_t ext_prog_req,
    input wire logic [13:0] ext_prog_rdata,
    input wire logic ext_prog_refused,
    input wire logic [13:0] ext_ee_rdata,
    input wire logic ext_ee_refused,
    input wire cwpc_pkg::cwpc_mem_req_t cpu_prog_req,
    input wire logic cpu_self_write_refused,
    input wire cwpc_pkg::cwpc_mem_fwd_t prog_fwd,
    input wire cwpc_pkg::cwpc_mem_fwd_t ee_fwd,
    input wire logic [13:0] prog_array_rdata,
    input wire logic clock_multiplier_enable,
    input wire logic [1:0] regulator_cap_pin_select,
    input wire logic low_voltage_prog_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase of a register transfer
    sequence apb_acc;
        psel && penable;
    endsequence
    // read of the second configuration word
    sequence cfg2_rd;
        apb_acc ##0 (!pwrite && paddr == cwpc_pkg::ADDR_CFG2);
    endsequence
    zero_wait_a: assert property (psel && !penable ##1 apb_acc |-> pready) else $error("access phase without ready");
    unmapped_err_a: assert property (apb_acc ##0 (!pwrite && paddr > 8'h0C) |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not flagged");
    unimpl_ones_a: assert property (cfg2_rd |-> (prdata[13:0] & 14'h08CC) == 14'h08CC)
        else $error("unimplemented bit read as zero");
    word_two_a: assert property (cfg2_rd |-> prdata[8] == clock_multiplier_enable
        && prdata[5:4] == regulator_cap_pin_select) else $error("applied outputs differ from word two");
    prog_block_a: assert property (ext_prog_refused && !cpu_prog_req.req |-> !prog_fwd.req)
        else $error("guarded program access passed on");
    prog_zero_a: assert property (ext_prog_refused && !ext_prog_req.wr |=> ext_prog_rdata == 14'h0)
        else $error("guarded program read not zero");
    cpu_read_a: assert property (cpu_prog_req.req && !cpu_prog_req.wr |-> prog_fwd.req && !cpu_self_write_refused
        && prog_fwd.addr == cpu_prog_req.addr) else $error("processor read held back");
    self_write_a: assert property (cpu_prog_req.req && cpu_prog_req.wr && !cpu_self_write_refused |-> prog_fwd.req
        && prog_fwd.wr && prog_fwd.wdata == cpu_prog_req.wdata) else $error("allowed self-write lost");
    ee_block_a: assert property (ext_ee_refused |-> !ee_fwd.req ##1 ext_ee_rdata == 14'h0)
        else $error("guarded eeprom access passed on");
    ext_pass_a: assert property (ext_prog_req.req && !ext_prog_req.wr && !ext_prog_refused && !cpu_prog_req.req
        |-> prog_fwd.req ##1 ext_prog_rdata == $past(prog_array_rdata)) else $error("open program read wrong");
    lvp_keep_a: assert property ($fell(low_voltage_prog_enable) |-> !$past(lv_entry_mode)
        && !$past(lv_entry_mode, 2)) else $error("low-voltage enable cleared in low-voltage entry");
endmodule // cwpc_monitor
bind cwpc_top cwpc_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .lv_entry_mode, .ext_prog_req, .ext_prog_rdata, .ext_prog_refused, .ext_ee_rdata, .ext_ee_refused,
    .cpu_prog_req, .cpu_self_write_refused, .prog_fwd, .ee_fwd, .prog_array_rdata, .clock_multiplier_enable,
    .regulator_cap_pin_select, .low_voltage_prog_enable);
`default_nettype wire

// File: tb/cwpc_prog_tool.sv
`timescale 1ns/1ns
`default_nettype none
// external programmer on the serial programming side
module cwpc_prog_tool (
    output cwpc_pkg::cwpc_mem_req_t prog_req,
    output cwpc_pkg::cwpc_mem_req_t ee_req
);
    // idle at time zero
    initial begin
        prog_req = '0;
        ee_req = '0;
    end
    // raise one request; called right at a rising edge
    task automatic start(input logic ee, input logic wr, input logic [11:0] a);
        if (ee) ee_req <= {1'b1, wr, a, 14'h2A5A};
        else prog_req <= {1'b1, wr, a, 14'h2A5A};
    endtask
    // release: address and data inverted so stale values never look valid
    task automatic stop;
        prog_req <= {2'b00, ~prog_req.addr, ~prog_req.wdata};
        ee_req <= {2'b00, ~ee_req.addr, ~ee_req.wdata};
    endtask
endmodule // cwpc_prog_tool
`default_nettype wire

// File: tb/test_code_and_write_protection_config.sv
`timescale 1ns/1ns
`default_nettype none
module test_code_and_write_protection_config;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lv_entry_mode, rd_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] ext_prog_rdata, ext_ee_rdata, prog_array_rdata, ee_array_rdata;
    logic ext_prog_refused, ext_ee_refused, cpu_self_write_refused, clock_multiplier_enable, low_voltage_prog_enable;
    logic [1:0] regulator_cap_pin_select;
    cwpc_pkg::cwpc_mem_req_t ext_prog_req, ext_ee_req, cpu_prog_req;
    cwpc_pkg::cwpc_mem_fwd_t prog_fwd, ee_fwd;
    logic [11:0] tops [4];
    int fail_count = 0;
    int cmp_count = 0;
    // arrays answer with a pattern of the address
    assign prog_array_rdata = {2'h1, prog_fwd.addr};
    assign ee_array_rdata = {6'h15, ee_fwd.addr[7:0]};
    cwpc_prog_tool tool (.prog_req(ext_prog_req), .ee_req(ext_ee_req));
    cwpc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .lv_entry_mode, .ext_prog_req, .ext_prog_rdata, .ext_prog_refused, .ext_ee_req, .ext_ee_rdata,
        .ext_ee_refused, .cpu_prog_req, .cpu_self_write_refused, .prog_fwd, .ee_fwd, .prog_array_rdata,
        .ee_array_rdata, .clock_multiplier_enable, .regulator_cap_pin_select, .low_voltage_prog_enable);
    // 50 ns clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // count and compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one register transfer, waiting for ready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for ready; only the watchdog ends a hung transfer
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // external access; guarded reads come back zero
    task automatic ext_try(input logic ee, input logic wr, input logic [11:0] a, input logic exp);
        @(posedge pclk);
        tool.start(ee, wr, a);
        #1 chk(ee ? ext_ee_refused : ext_prog_refused, exp);
        @(posedge pclk);
        tool.stop();
        #1 if (!wr) chk(ee ? ext_ee_rdata : ext_prog_rdata, exp ? 0 : ee ? {6'h15, a[7:0]} : {2'h1, a});
    endtask
    // processor access on program memory
    task automatic cpu_try(input logic wr, input logic [11:0] a, input logic exp);
        @(posedge pclk);
        cpu_prog_req <= {1'b1, wr, a, 14'h1555};
        #1 chk(cpu_self_write_refused, exp);
        chk(prog_fwd.req, !exp);
        @(posedge pclk);
        cpu_prog_req.req <= 1'b0;
    endtask
    // timeout guard
    initial begin
        repeat (4000) @(posedge pclk);
        fail_count++;
        report_and_stop();
    end
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, lv_entry_mode} = '0;
        cpu_prog_req = '0;
        tops = '{cwpc_pkg::WRT_ALL_TOP, cwpc_pkg::WRT_HALF_TOP, cwpc_pkg::WRT_SMALL_TOP, 12'hFFF};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, cwpc_pkg::ADDR_CFG2, 0); chk(rd, 32'h3FFF);
        apb(0, 8'h10, 0); chk(rd_err, 32'h1); chk(rd, 32'h0);
        $display("test reset done");
        // keep the low-voltage enable set so that the refused clear below is seen
        apb(1, cwpc_pkg::ADDR_CFG2, 32'h2000); apb(1, cwpc_pkg::ADDR_CTRL, 1);
        apb(0, cwpc_pkg::ADDR_CFG2, 0); chk(rd, 32'h28CC);
        chk({clock_multiplier_enable, regulator_cap_pin_select, low_voltage_prog_enable}, 32'h1);
        lv_entry_mode <= 1'b1;
        apb(1, cwpc_pkg::ADDR_CFG2, 32'h0100); apb(1, cwpc_pkg::ADDR_CTRL, 3);
        apb(0, cwpc_pkg::ADDR_CFG2, 0); chk(rd, 32'h29FC);
        apb(0, cwpc_pkg::ADDR_STATUS, 0); chk(rd[2], 1);
        lv_entry_mode <= 1'b0;
        $display("test word two done");
        for (int c = 0; c < 4; c++) begin
            apb(1, cwpc_pkg::ADDR_CFG2, c); apb(1, cwpc_pkg::ADDR_CTRL, 3);
            cpu_try(1, 12'h000, c != 3);
            cpu_try(1, tops[c], c != 3);
            cpu_try(1, tops[c] + 12'h1, c == 0);
            cpu_try(0, 12'h000, 0);
        end
        $display("test write guard done");
        apb(1, cwpc_pkg::ADDR_CFG1, 32'h3F7F); apb(1, cwpc_pkg::ADDR_CTRL, 3);
        apb(1, cwpc_pkg::ADDR_STATUS, 32'h1C); // clear the sticky flags left by earlier tests
        ext_try(0, 0, 12'h0A5, 1); ext_try(0, 1, 12'h0A6, 1); ext_try(1, 0, 12'h033, 0);
        cpu_try(0, 12'h0A5, 0);
        apb(0, cwpc_pkg::ADDR_STATUS, 0); chk(rd[4:0], 5'h09);
        apb(1, cwpc_pkg::ADDR_CFG1, 32'h3EFF); apb(1, cwpc_pkg::ADDR_CTRL, 3);
        ext_try(1, 0, 12'h044, 1); ext_try(1, 1, 12'h045, 1); ext_try(0, 0, 12'h123, 0);
        apb(0, cwpc_pkg::ADDR_STATUS, 0); chk(rd[1:0], 2'h2);
        $display("test code guard done");
        report_and_stop();
    end
endmodule // test_code_and_write_protection_config
`default_nettype wire
